// ---- design/qrf_pkg.sv ----
// Package: constants and types for the quadlet receive formatter
// How it works
// - Host FIFO stream starts every packet with the generated status trailer.
// - FIFO second quadlet: target address high, tag/retry/code/priority low.
// - FIFO third quadlet: sender high, offset upper low; fourth is offset lower.
// - Data quadlet only for write requests and read responses; else omitted.
// - Data-mover first quadlet: target address high, packet control low.
// - Data-mover second/third quadlets: sender, 48-bit offset; data fourth.
// - Data-mover stream ends every packet with the status trailer.
// - Trailer count equals header plus payload quadlets, trailer excluded.
// - Trailer holds the 5-bit acknowledge result of the packet.
// - Trailer speed code 00/01/10 for 100/200/400; 11 flagged undefined.
// - Target address is 10-bit bus number above 6-bit node number.
// - Retry code 00 new, 01 retry_X, 10 retry_A, 11 retry_B.
// - In cable mode the priority field is reported as zeros.
// - Offset quadlet aligned; lock responses keep response code, zero reserved.
// - Transaction tag passes through unchanged.
// - Sender field carries the transmitting node identifier.
package qrf_pkg;
  localparam int QUAD_W        = 32;
  localparam int ADDR_W        = 8;
  // Trailer field layout (bit 0 = LSB)
  localparam int TRL_COUNT_LSB = 16;
  localparam int TRL_COUNT_W   = 14;
  localparam int TRL_ACK_LSB   = 8;
  localparam int ACK_W         = 5;
  localparam int TRL_SPD_LSB   = 4;
  localparam int SPD_W         = 2;
  // Packet control field layout
  localparam int TAG_LSB       = 10;
  localparam int TAG_W         = 6;
  localparam int RETRY_LSB     = 8;
  localparam int TRANSACTION_CODE_LSB     = 4;
  localparam int TRANSACTION_CODE_W       = 4;
  localparam int PRIO_W        = 4;
  localparam int BUS_W         = 10;
  localparam int NODE_W        = 6;
  localparam int OFFSET_W      = 48;
  localparam int LOCK_RCODE_W  = 4;
  // Transaction codes of quadlet packets
  localparam logic [3:0] TRANSACTION_CODE_WR_QUAD_REQ  = 4'h0;
  localparam logic [3:0] TRANSACTION_CODE_WR_RESP      = 4'h2;
  localparam logic [3:0] TRANSACTION_CODE_RD_QUAD_REQ  = 4'h4;
  localparam logic [3:0] TRANSACTION_CODE_RD_QUAD_RESP = 4'h6;
  localparam logic [3:0] TRANSACTION_CODE_LOCK_RESP    = 4'hb;
  // Speed and retry codes
  localparam logic [1:0] SPD_100       = 2'h0;
  localparam logic [1:0] SPD_200       = 2'h1;
  localparam logic [1:0] SPD_400       = 2'h2;
  localparam logic [1:0] SPD_UNDEF     = 2'h3;
  localparam logic [1:0] RETRY_NEW     = 2'h0;
  localparam logic [1:0] RETRY_X       = 2'h1;
  localparam logic [1:0] RETRY_A       = 2'h2;
  localparam logic [1:0] RETRY_B       = 2'h3;
  // Quadlets before the data quadlet
  localparam logic [2:0] HDR_QUADS     = 3'h3;
  // Register map
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_PKTCOUNT = 8'h08;
  localparam logic [7:0] ADDR_TRAILER  = 8'h0c;
  localparam int CTRL_ENABLE_BIT       = 0;
  localparam int CTRL_CABLE_BIT        = 1;
  localparam logic [1:0] CTRL_RESET    = 2'h3;
  localparam int STATUS_BUSY_BIT       = 0;
  localparam int STATUS_UNDEF_BIT      = 1;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // Register select codes
  localparam logic [2:0] SEL_CTRL      = 3'h0;
  localparam logic [2:0] SEL_STATUS    = 3'h1;
  localparam logic [2:0] SEL_PKTCOUNT  = 3'h2;
  localparam logic [2:0] SEL_TRAILER   = 3'h3;
  localparam logic [2:0] SEL_NONE      = 3'h7;

  typedef enum logic {ST_IDLE, ST_EMIT} qrf_state_e;
endpackage

// ---- design/qrf_receive_formatter.sv ----
// Quadlet receive formatter: builds FIFO and data-mover streams, AXI4-Lite regs
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module qrf_receive_formatter (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // AXI4-Lite write address and data
  input  wire logic                    s_axi_awvalid,
  input  wire logic [7:0]              s_axi_awaddr,
  output logic                         s_axi_awready,
  input  wire logic                    s_axi_wvalid,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic                         s_axi_bvalid,
  output logic [1:0]                   s_axi_bresp,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic                    s_axi_arvalid,
  input  wire logic [7:0]              s_axi_araddr,
  output logic                         s_axi_arready,
  output logic                         s_axi_rvalid,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  input  wire logic                    s_axi_rready,
  // Received packet, one per handshake
  input  wire logic                    rxValid,
  output logic                         rxReady,
  input  wire logic [9:0]              rxBusNumber,
  input  wire logic [5:0]              rxNodeNumber,
  input  wire logic [5:0]              rxTransactionTag,
  input  wire logic [1:0]              rxRetryCode,
  input  wire logic [3:0]              rxTransactionCode,
  input  wire logic [3:0]              rxPriority,
  input  wire logic [15:0]             rxSenderNodeAddress,
  input  wire logic [47:0]             rxTargetOffset,
  input  wire logic [31:0]             rxQuadletData,
  input  wire logic [4:0]              rxAckResult,
  input  wire logic [1:0]              rxSpeed,
  // Host FIFO quadlet stream
  output logic                         fifoValid,
  output logic [31:0]                  fifoData,
  output logic                         fifoLast,
  input  wire logic                    fifoReady,
  // Data-mover quadlet stream
  output logic                         dmValid,
  output logic [31:0]                  dmData,
  output logic                         dmLast,
  input  wire logic                    dmReady
);
  // Picks word k (0..3) of the data-mover ordering: three header words, then data
  function automatic logic [31:0] pickWord(input logic [2:0] k, input logic [31:0] w0,
                                           input logic [31:0] w1, input logic [31:0] w2,
                                           input logic [31:0] w3);
    logic [31:0] r;
    r = w3;
    if (k == 3'h0)
      r = w0;
    else if (k == 3'h1)
      r = w1;
    else if (k == 3'h2)
      r = w2;
    return r;
  endfunction

  // Register select from a byte address; shared by read and write paths
  function automatic logic [2:0] regSelect(input logic [7:0] addr);
    logic [2:0] s;
    s = qrf_pkg::SEL_NONE;
    if (addr == qrf_pkg::ADDR_CTRL)
      s = qrf_pkg::SEL_CTRL;
    else if (addr == qrf_pkg::ADDR_STATUS)
      s = qrf_pkg::SEL_STATUS;
    else if (addr == qrf_pkg::ADDR_PKTCOUNT)
      s = qrf_pkg::SEL_PKTCOUNT;
    else if (addr == qrf_pkg::ADDR_TRAILER)
      s = qrf_pkg::SEL_TRAILER;
    return s;
  endfunction

  // Packet state
  qrf_pkg::qrf_state_e state_q;
  qrf_pkg::qrf_state_e state_d;
  logic        rxReady_q;
  logic [31:0] hdr0_q;
  logic [31:0] hdr1_q;
  logic [31:0] hdr2_q;
  logic [31:0] data_q;
  logic [31:0] trailer_q;
  logic [2:0]  lastIdx_q;
  logic [2:0]  fifoIdx_q;
  logic [2:0]  dmIdx_q;
  logic        fifoDone_q;
  logic        dmDone_q;
  // Register file
  logic [1:0]  ctrl_q;
  logic        undefSpeed_q;
  logic [31:0] pktCount_q;
  logic [31:0] lastTrailer_q;
  // AXI state
  logic        awHeld_q;
  logic        wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Packet capture and field formatting
  logic        take;
  logic        hasData;
  logic        isLock;
  logic [15:0] targetAddr;
  logic [3:0]  prioOut;
  logic [47:0] offsetOut;
  logic [2:0]  quadCount;
  logic [31:0] trailerWord;
  logic [31:0] hdr0Word;
  logic [31:0] hdr1Word;

  assign take       = rxValid & rxReady_q & (state_q == qrf_pkg::ST_IDLE);
  // Data quadlet only for write request and read response
  assign hasData    = (rxTransactionCode == qrf_pkg::TRANSACTION_CODE_WR_QUAD_REQ) |
                      (rxTransactionCode == qrf_pkg::TRANSACTION_CODE_RD_QUAD_RESP);
  assign isLock     = rxTransactionCode == qrf_pkg::TRANSACTION_CODE_LOCK_RESP;
  assign targetAddr = {rxBusNumber, rxNodeNumber};
  // Cable mode forces priority to zero
  assign prioOut    = ctrl_q[qrf_pkg::CTRL_CABLE_BIT] ? 4'h0 : rxPriority;
  // Quadlet aligned; lock response keeps its code, reserved bits cleared
  assign offsetOut  = isLock ?
                      {rxTargetOffset[47:44], 12'h000, rxTargetOffset[31:2], 2'h0} :
                      {rxTargetOffset[47:2], 2'h0};
  // Header plus payload quadlets, trailer not counted
  assign quadCount  = qrf_pkg::HDR_QUADS + {2'h0, hasData};
  // All other trailer bits stay zero
  assign trailerWord = {2'h0, 11'h000, quadCount, 3'h0, rxAckResult, 2'h0, rxSpeed,
                        4'h0};
  // Target address above tag, retry, code and priority
  assign hdr0Word   = {targetAddr, rxTransactionTag, rxRetryCode, rxTransactionCode,
                       prioOut};
  assign hdr1Word   = {rxSenderNodeAddress, offsetOut[47:32]};

  // Stream word selection
  logic        fifoInValid;
  logic        fifoInReady;
  logic [31:0] fifoWord;
  logic        fifoWordLast;
  logic        fifoPush;
  logic        dmInValid;
  logic        dmInReady;
  logic [31:0] dmWord;
  logic        dmWordLast;
  logic        dmPush;
  logic        fifoFinish;
  logic        dmFinish;

  assign fifoInValid  = (state_q == qrf_pkg::ST_EMIT) & ~fifoDone_q;
  assign dmInValid    = (state_q == qrf_pkg::ST_EMIT) & ~dmDone_q;
  // FIFO: trailer first, then header and data
  assign fifoWord     = (fifoIdx_q == 3'h0) ? trailer_q :
                        pickWord(fifoIdx_q - 3'h1, hdr0_q, hdr1_q, hdr2_q, data_q);
  // Data mover: header and data first, trailer last
  assign dmWord       = (dmIdx_q == lastIdx_q) ? trailer_q :
                        pickWord(dmIdx_q, hdr0_q, hdr1_q, hdr2_q, data_q);
  assign fifoWordLast = fifoIdx_q == lastIdx_q;
  assign dmWordLast   = dmIdx_q == lastIdx_q;
  assign fifoPush     = fifoInValid & fifoInReady;
  assign dmPush       = dmInValid & dmInReady;
  assign fifoFinish   = fifoDone_q | (fifoPush & fifoWordLast);
  assign dmFinish     = dmDone_q | (dmPush & dmWordLast);

  // Next state: next packet only once both streams hold the whole packet
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      qrf_pkg::ST_IDLE:
        if (take)
          state_d = qrf_pkg::ST_EMIT;
      qrf_pkg::ST_EMIT:
        if (fifoFinish & dmFinish)
          state_d = qrf_pkg::ST_IDLE;
      default:
        state_d = qrf_pkg::ST_IDLE;
    endcase
  end

  // State and receive ready; enable bit gates new packets
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_q   <= qrf_pkg::ST_IDLE;
      rxReady_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      rxReady_q <= (state_d == qrf_pkg::ST_IDLE) & ctrl_q[qrf_pkg::CTRL_ENABLE_BIT];
    end

  // Packet words held for the whole emission
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      hdr0_q    <= '0;
      hdr1_q    <= '0;
      hdr2_q    <= '0;
      data_q    <= '0;
      trailer_q <= '0;
      lastIdx_q <= '0;
    end
    else if (take)
    begin
      hdr0_q    <= hdr0Word;
      hdr1_q    <= hdr1Word;
      hdr2_q    <= offsetOut[31:0];
      data_q    <= rxQuadletData;
      trailer_q <= trailerWord;
      lastIdx_q <= quadCount;
    end

  // Independent word indices, so one stalled stream does not stall the other
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      fifoIdx_q  <= '0;
      dmIdx_q    <= '0;
      fifoDone_q <= 1'b0;
      dmDone_q   <= 1'b0;
    end
    else if (take)
    begin
      fifoIdx_q  <= '0;
      dmIdx_q    <= '0;
      fifoDone_q <= 1'b0;
      dmDone_q   <= 1'b0;
    end
    else
    begin
      if (fifoPush)
        fifoIdx_q <= fifoIdx_q + 3'h1;
      if (dmPush)
        dmIdx_q <= dmIdx_q + 3'h1;
      fifoDone_q <= fifoFinish;
      dmDone_q   <= dmFinish;
    end

  // Output buffers: a stalled reader loses no quadlet
  qrf_skid_buffer #(.WIDTH(33)) fifoBuf (
    .clk      (clk),
    .rst      (rst),
    .inValid  (fifoInValid),
    .inData   ({fifoWordLast, fifoWord}),
    .inReady  (fifoInReady),
    .outValid (fifoValid),
    .outData  ({fifoLast, fifoData}),
    .outReady (fifoReady)
  );

  qrf_skid_buffer #(.WIDTH(33)) dmBuf (
    .clk      (clk),
    .rst      (rst),
    .inValid  (dmInValid),
    .inData   ({dmWordLast, dmWord}),
    .inReady  (dmInReady),
    .outValid (dmValid),
    .outData  ({dmLast, dmData}),
    .outReady (dmReady)
  );

  // AXI write channel bookkeeping
  logic        awTake;
  logic        wTake;
  logic        wrFire;
  logic        awHeldD;
  logic        wHeldD;
  logic        bvalidD;
  logic [2:0]  wrSel;
  logic        undefSet;
  logic        undefClr;

  assign awTake   = s_axi_awvalid & awready_q;
  assign wTake    = s_axi_wvalid & wready_q;
  assign wrFire   = awHeld_q & wHeld_q & ~bvalid_q;
  assign awHeldD  = (awHeld_q | awTake) & ~wrFire;
  assign wHeldD   = (wHeld_q | wTake) & ~wrFire;
  assign bvalidD  = wrFire | (bvalid_q & ~s_axi_bready);
  assign wrSel    = regSelect(awAddr_q);
  // Undefined speed code seen; new event beats a same-cycle clear
  assign undefSet = take & (rxSpeed == qrf_pkg::SPD_UNDEF);
  assign undefClr = wrFire & (wrSel == qrf_pkg::SEL_STATUS) & wStrb_q[0] &
                    wData_q[qrf_pkg::STATUS_UNDEF_BIT];

  // Address and data latches, taken in either order
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      awHeld_q  <= 1'b0;
      wHeld_q   <= 1'b0;
      awAddr_q  <= '0;
      wData_q   <= '0;
      wStrb_q   <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end
    else
    begin
      awHeld_q  <= awHeldD;
      wHeld_q   <= wHeldD;
      awready_q <= ~awHeldD & ~bvalidD;
      wready_q  <= ~wHeldD & ~bvalidD;
      if (awTake)
        awAddr_q <= s_axi_awaddr;
      if (wTake)
      begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= qrf_pkg::RESP_OKAY;
    end
    else
    begin
      bvalid_q <= bvalidD;
      if (wrFire)
        bresp_q <= (wrSel == qrf_pkg::SEL_NONE) ? qrf_pkg::RESP_SLVERR : qrf_pkg::RESP_OKAY;
    end

  // Control register and status counters
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ctrl_q        <= qrf_pkg::CTRL_RESET;
      undefSpeed_q  <= 1'b0;
      pktCount_q    <= '0;
      lastTrailer_q <= '0;
    end
    else
    begin
      if (wrFire & (wrSel == qrf_pkg::SEL_CTRL) & wStrb_q[0])
        ctrl_q <= wData_q[1:0];
      undefSpeed_q <= undefSet | (undefSpeed_q & ~undefClr);
      if (take)
      begin
        pktCount_q    <= pktCount_q + 32'h1;
        lastTrailer_q <= trailerWord;
      end
    end

  // AXI read path, answer one cycle after the address is taken
  logic        arTake;
  logic        rvalidD;
  logic [2:0]  rdSel;
  logic [31:0] rdWord;

  assign arTake  = s_axi_arvalid & arready_q;
  assign rvalidD = arTake | (rvalid_q & ~s_axi_rready);
  assign rdSel   = regSelect(s_axi_araddr);
  assign rdWord  = (rdSel == qrf_pkg::SEL_CTRL)     ? {30'h0, ctrl_q} :
                   (rdSel == qrf_pkg::SEL_STATUS)   ?
                     {30'h0, undefSpeed_q, state_q == qrf_pkg::ST_EMIT} :
                   (rdSel == qrf_pkg::SEL_PKTCOUNT) ? pktCount_q :
                   (rdSel == qrf_pkg::SEL_TRAILER)  ? lastTrailer_q : 32'h0;

  // Read data held until rready
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= qrf_pkg::RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rvalidD;
      rvalid_q  <= rvalidD;
      if (arTake)
      begin
        rdata_q <= rdWord;
        rresp_q <= (rdSel == qrf_pkg::SEL_NONE) ? qrf_pkg::RESP_SLVERR : qrf_pkg::RESP_OKAY;
      end
    end

  // Bus outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rxReady       = rxReady_q;
endmodule // qrf_receive_formatter

// ---- design/qrf_skid_buffer.sv ----
// Two-entry buffer with registered outputs on both sides
`timescale 1ns/1ns
module qrf_skid_buffer #(
  parameter int WIDTH = 33
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Draining side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  logic             outValid_q;
  logic [WIDTH-1:0] outData_q;
  logic             skidValid_q;
  logic [WIDTH-1:0] skidData_q;
  logic             inReady_q;
  logic             push;
  logic             drain;

  // Second entry catches a word while the output is stalled
  assign push     = inValid & inReady_q;
  assign drain    = ~outValid_q | outReady;
  assign inReady  = inReady_q;
  assign outValid = outValid_q;
  assign outData  = outData_q;

  // Output entry
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      outValid_q <= 1'b0;
      outData_q  <= '0;
    end
    else if (drain)
    begin
      outValid_q <= skidValid_q | push;
      outData_q  <= skidValid_q ? skidData_q : inData;
    end

  // Skid entry and registered ready; ready drops as soon as skid fills
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      skidValid_q <= 1'b0;
      skidData_q  <= '0;
      inReady_q   <= 1'b0;
    end
    else
    begin
      if (drain)
        skidValid_q <= 1'b0;
      else if (push)
      begin
        skidValid_q <= 1'b1;
        skidData_q  <= inData;
      end
      inReady_q <= drain | ~(skidValid_q | push);
    end
endmodule // qrf_skid_buffer

// ---- tb/qrf_receive_formatter_asserts.sv ----
// Checker of the formatter's received-packet streams
`timescale 1ns/1ns
module qrf_receive_formatter_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Receive side
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic [9:0]  rxBusNumber,
  input wire logic [5:0]  rxNodeNumber,
  input wire logic [5:0]  rxTransactionTag,
  input wire logic [4:0]  rxAckResult,
  input wire logic [1:0]  rxSpeed,
  // Output streams
  input wire logic        fifoValid,
  input wire logic [31:0] fifoData,
  input wire logic        fifoReady,
  input wire logic        dmValid,
  input wire logic [31:0] dmData,
  input wire logic        dmLast,
  input wire logic        dmReady
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Trailer shape: zero gaps, count of three or four
  function automatic logic trlOk(input logic [31:0] w);
    return w[31:30] == 2'h0 && w[15:13] == 3'h0 && w[7:6] == 2'h0 && w[3:0] == 4'h0
      && (w[29:16] == 14'h3 || w[29:16] == 14'h4);
  endfunction

  // Take with both buffers empty: word0 timing fixed
  sequence s_take; rxValid && rxReady && !fifoValid && !dmValid; endsequence
  sequence s_accept; rxValid && rxReady; endsequence
  sequence s_fifoStall; fifoValid && !fifoReady; endsequence
  sequence s_dmStall; dmValid && !dmReady; endsequence

  property p_fifoTrailer;
    s_take |-> ##2 fifoValid && fifoData[12:8] == $past(rxAckResult, 2)
      && fifoData[5:4] == $past(rxSpeed, 2);
  endproperty
  a_fifoTrailer: assert property (p_fifoTrailer) else $error("fifo trailer");
  property p_fifoFormat; s_take |-> ##2 trlOk(fifoData); endproperty
  a_fifoFormat: assert property (p_fifoFormat) else $error("fifo trailer shape");
  property p_dmTarget;
    s_take |-> ##2 dmValid && dmData[31:16] == $past({rxBusNumber, rxNodeNumber}, 2);
  endproperty
  a_dmTarget: assert property (p_dmTarget) else $error("dm target address");
  property p_dmTag; s_take |-> ##2 dmData[15:10] == $past(rxTransactionTag, 2); endproperty
  a_dmTag: assert property (p_dmTag) else $error("dm tag changed");
  property p_dmTrailer; dmValid && dmLast |-> trlOk(dmData); endproperty
  a_dmTrailer: assert property (p_dmTrailer) else $error("dm trailer shape");
  property p_fifoHold; s_fifoStall |=> fifoValid && $stable(fifoData); endproperty
  a_fifoHold: assert property (p_fifoHold) else $error("fifo word lost");
  property p_dmHold; s_dmStall |=> dmValid && $stable(dmData) && $stable(dmLast); endproperty
  a_dmHold: assert property (p_dmHold) else $error("dm word lost");
  property p_busy; s_accept |=> !rxReady [*3]; endproperty
  a_busy: assert property (p_busy) else $error("taken mid-packet");
endmodule // qrf_receive_formatter_asserts

bind qrf_receive_formatter qrf_receive_formatter_asserts u_qrf_receive_formatter_asserts (
  .clk(clk), .rst(rst), .rxValid(rxValid), .rxReady(rxReady), .rxBusNumber(rxBusNumber),
  .rxNodeNumber(rxNodeNumber), .rxTransactionTag(rxTransactionTag), .rxAckResult(rxAckResult),
  .rxSpeed(rxSpeed), .fifoValid(fifoValid), .fifoData(fifoData), .fifoReady(fifoReady),
  .dmValid(dmValid), .dmData(dmData), .dmLast(dmLast), .dmReady(dmReady));

// ---- tb/qrf_receive_formatter_tb.sv ----
// Self-checking bench of the quadlet receive formatter
`timescale 1ns/1ns
module qrf_receive_formatter_tb;
  logic        clk, rst = 1'b1, slow = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rxValid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rxQuadletData = 32'h0, fifoData, dmData;
  logic [3:0]  s_axi_wstrb = 4'hf, rxTransactionCode = 4'h0, rxPriority = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rxRetryCode = 2'h0, rxSpeed = 2'h0, resp;
  logic [9:0]  rxBusNumber = 10'h0;
  logic [5:0]  rxNodeNumber = 6'h0, rxTransactionTag = 6'h0;
  logic [15:0] rxSenderNodeAddress = 16'h0, lf = 16'h13ba;
  logic [47:0] rxTargetOffset = 48'h0;
  logic [4:0]  rxAckResult = 5'h0;
  logic        rxReady, fifoValid, fifoLast, fifoReady, dmValid, dmLast, dmReady;
  logic [31:0] rd, lastTrl;
  logic [3:0]  codes [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hb};
  logic [32:0] fq [$], dq [$];
  int          mismatches = 0, checks = 0;

  qrf_receive_formatter u_qrf_receive_formatter (.*);
  qrf_stream_sink u_fifo_sink (.clk(clk), .rst(rst), .slow(slow), .valid(fifoValid),
    .ready(fifoReady));
  qrf_stream_sink u_dm_sink (.clk(clk), .rst(rst), .slow(slow), .valid(dmValid),
    .ready(dmReady));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string n, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Step the random source, Fibonacci taps
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  // One write; trailing edge keeps drives apart
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // Offer one packet, queue both expected streams; valid stays up
  task automatic sendPkt(input logic [3:0] tc, input logic [1:0] sp, input logic cable);
    logic [15:0] a, b, c, d;
    logic [47:0] off;
    logic [31:0] h0, trl;
    logic        dat;
    a = rnd();
    b = rnd();
    c = rnd();
    d = rnd();
    {rxBusNumber, rxNodeNumber} <= a;
    rxTransactionTag <= b[5:0];
    rxRetryCode <= sp;
    rxTransactionCode <= tc;
    rxPriority <= b[9:6];
    rxSenderNodeAddress <= c;
    rxTargetOffset <= {d, c, b};
    rxQuadletData <= {a, d};
    rxAckResult <= b[14:10];
    rxSpeed <= sp;
    rxValid <= 1'b1;
    dat = tc == qrf_pkg::TRANSACTION_CODE_WR_QUAD_REQ || tc == qrf_pkg::TRANSACTION_CODE_RD_QUAD_RESP;
    off = {d, c, b[15:2], 2'h0};
    if (tc == qrf_pkg::TRANSACTION_CODE_LOCK_RESP) off[43:32] = 12'h0;
    h0 = {a, b[5:0], sp, tc, cable ? 4'h0 : b[9:6]};
    trl = {2'h0, dat ? 14'h4 : 14'h3, 3'h0, b[14:10], 2'h0, sp, 4'h0};
    fq.push_back({1'b0, trl});
    fq.push_back({1'b0, h0});
    fq.push_back({1'b0, c, off[47:32]});
    fq.push_back({!dat, off[31:0]});
    dq.push_back({1'b0, h0});
    dq.push_back({1'b0, c, off[47:32]});
    dq.push_back({1'b0, off[31:0]});
    if (dat) fq.push_back({1'b1, a, d});
    if (dat) dq.push_back({1'b0, a, d});
    dq.push_back({1'b1, trl});
    lastTrl = trl;
    do @(posedge clk); while (!rxReady);
  endtask
  // Model compared at every accepted word
  always @(posedge clk)
  begin
    if (fifoValid && fifoReady)
      check("fifo", {fifoLast, fifoData}, fq.pop_front());
    if (dmValid && dmReady)
      check("dm", {dmLast, dmData}, dq.pop_front());
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    axr(qrf_pkg::ADDR_CTRL, rd, resp);
    check("ctrl", {1'b0, rd}, {31'h0, qrf_pkg::CTRL_RESET});
    axr(8'h40, rd, resp);
    check("rdata", {1'b0, rd}, 33'h0);
    check("rdresp", {31'h0, resp}, {31'h0, qrf_pkg::RESP_SLVERR});
    axw(8'h40, 32'h0, resp);
    check("wrresp", {31'h0, resp}, {31'h0, qrf_pkg::RESP_SLVERR});
    // Every code, retry and speed, both readers slow together on every other pair of packets
    for (int i = 0; i < 10; i++)
    begin
      slow <= i[1];
      sendPkt(codes[i % 5], i[1:0], 1'b1);
    end
    rxValid <= 1'b0;
    repeat (60) @(posedge clk);
    check("drain", 33'(fq.size() + dq.size()), 33'h0);
    axr(qrf_pkg::ADDR_STATUS, rd, resp);
    check("undef", {32'h0, rd[qrf_pkg::STATUS_UNDEF_BIT]}, 33'h1);
    axw(qrf_pkg::ADDR_STATUS, 32'h2, resp);
    axr(qrf_pkg::ADDR_STATUS, rd, resp);
    check("status", {1'b0, rd}, 33'h0);
    axr(qrf_pkg::ADDR_PKTCOUNT, rd, resp);
    check("pkts", {1'b0, rd}, 33'ha);
    axr(qrf_pkg::ADDR_TRAILER, rd, resp);
    check("trailer", {1'b0, rd}, {1'b0, lastTrl});
    // Cable mode off: priority passes through
    axw(qrf_pkg::ADDR_CTRL, 32'h1, resp);
    sendPkt(qrf_pkg::TRANSACTION_CODE_WR_QUAD_REQ, 2'h2, 1'b0);
    rxValid <= 1'b0;
    repeat (30) @(posedge clk);
    check("drain", 33'(fq.size() + dq.size()), 33'h0);
    end_of_test();
  end
endmodule // qrf_receive_formatter_tb

// ---- tb/qrf_stream_sink.sv ----
// Stream reader model standing at one formatter output
`timescale 1ns/1ns
module qrf_stream_sink (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pace select and stream handshake
  input  wire logic slow,
  input  wire logic valid,
  output logic      ready
);
  logic [1:0] paceQ;

  // Slow reader takes one word in four, so the buffer fills
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst) paceQ <= 2'h0;
    else paceQ <= paceQ + 2'h1;
  end

  assign ready = !rst && (!slow || paceQ == 2'h0);
endmodule // qrf_stream_sink
